// ==== rtl/mtcs_top.sv ====
// transmit configuration, sequencing and transmit status of the mac
// Functional notes
// - loopback field clears to zero at reset
// - append fcs unless crc inhibit set
// - crc inhibit still honoured during loopback
// - decode four loopback modes from two bits
// - only mode 2 drives loopback pin high
// - hash 62 disables, 63 enables transmitter
// - clearing auto disable re-enables transmitter
// - offset mode widens first three backoffs
// - otherwise truncated binary exponential backoff
// - status clears when host starts transmission
// - status bits low unless event occurs
// - sent ok only without abort or underrun
// - flag collisions and count them
// - abort after sixteen attempts in total
// - flag carrier loss, keep transmitting
// - underrun sets flag and aborts packet
// - flag missing heartbeat in 6.4 us window
// - flag late collision, reschedule as usual
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module mtcs_top #(
   parameter int unsigned SLOT_CYC = mtcs_pkg::SLOT_CYC_DEF  // cycles per slot time
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   input  wire logic [7:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic [7:0]                    reg_rdata,
   input  wire logic                     tx_go,
   input  wire mtcs_pkg::mtcs_ser_evt_t  ser_evt,
   input  wire mtcs_pkg::mtcs_hash_evt_t hash_evt,
   input  wire logic                     carrier_sense_pin,
   input  wire logic                     collision_pin,
   output logic                          transmit_enable_out,
   output logic                          append_fcs,
   output logic                          loopback_pin,
   output logic                          internal_loopback,
   output logic                          external_loopback,
   output logic                          tx_busy
);
   import mtcs_pkg::*;

   // counter limits at counter width
   localparam logic [CYC_W-1:0] SLOT_LAST = CYC_W'(SLOT_CYC - 1);
   localparam logic [CYC_W-1:0] SLOT_FULL = CYC_W'(SLOT_CYC);
   localparam logic [CYC_W-1:0] HB_LAST   = CYC_W'(HB_CYC - 1);

   // refuse slot counts the counter cannot hold
   if (SLOT_CYC < 2 || SLOT_CYC > 65535) begin : g_bad_slot
      $error("SLOT_CYC out of range");
   end

   mtcs_cfg_t         cfg_q;       // transmit_configuration
   mtcs_status_t      stat_q;      // transmit_status
   mtcs_state_t       st_q;        // sequencer state
   logic [CYC_W-1:0]  cyc_q;       // cycle timer
   logic [9:0]        slot_q;      // backoff slots left
   logic [4:0]        coll_cnt_q;  // collision_count
   logic              transmit_enable_out_q;      // transmit enable flop
   logic              tx_off_q;    // remote disable latch
   logic              crs_mon_q;   // carrier watch armed
   logic              hb_seen_q;   // heartbeat observed
   logic [15:0]       lfsr_q;      // random source
   logic              crs_meta_q;  // carrier sync stage 1
   logic              crs_q;       // carrier sync stage 2
   logic              col_meta_q;  // collision sync stage 1
   logic              col_q;       // collision sync stage 2
   logic              col_prev_q;  // collision edge history

   // decoded conditions
   logic              go_ok;
   logic              in_send;
   logic              col_rise;
   logic              urun;
   logic              coll_take;
   logic              done;
   logic              last_try;
   logic              late;
   logic              hb_end;
   logic [4:0]        coll_next;
   logic [3:0]        bo_exp;
   logic [9:0]        bo_mask;

   // configuration register, write only
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_q <= CFG_RESET;
      end else if (reg_wr && reg_addr == XMIT_CONFIG_ADDR) begin
         cfg_q <= mtcs_cfg_t'({3'h0, reg_wdata[4:0]});
      end
   end

   // fcs control holds in every loopback mode
   assign append_fcs = !cfg_q.crc_inhibit;

   // loopback decode; pin only high in mode 2
   assign loopback_pin      = (cfg_q.loopback_sel == LB_EXT_PIN);
   assign internal_loopback = (cfg_q.loopback_sel == LB_INTERNAL);
   assign external_loopback = cfg_q.loopback_sel[1];

   // pin synchronisers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         crs_meta_q <= 1'b0;
         crs_q      <= 1'b0;
         col_meta_q <= 1'b0;
         col_q      <= 1'b0;
         col_prev_q <= 1'b0;
      end else begin
         crs_meta_q <= carrier_sense_pin;
         crs_q      <= crs_meta_q;
         col_meta_q <= collision_pin;
         col_q      <= col_meta_q;
         col_prev_q <= col_q;
      end
   end

   // free running random source for backoff
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lfsr_q <= LFSR_SEED;
      end else begin
         lfsr_q <= {lfsr_q[14:0], ^(lfsr_q & LFSR_TAPS)};
      end
   end

   // event decode; underrun beats collision beats frame end
   assign in_send   = (st_q == ST_SEND);
   assign col_rise  = col_q && !col_prev_q;
   assign go_ok     = tx_go && (st_q == ST_IDLE) && !tx_off_q;
   assign urun      = in_send && ser_evt.underrun;
   assign coll_take = in_send && col_rise && !ser_evt.underrun;
   assign done      = in_send && ser_evt.frame_done && !col_rise && !ser_evt.underrun;
   assign coll_next = coll_cnt_q + 5'h01;
   assign last_try  = (coll_next == MAX_ATTEMPTS);
   assign late      = (cyc_q >= SLOT_FULL);
   assign hb_end    = (st_q == ST_IFG) && (cyc_q == HB_LAST);

   // backoff window for the collision about to be counted
   always_comb begin
      if (cfg_q.collision_offset_enable && coll_next <= COLLISION_OFFSET_ENABLE_COLLS) begin
         bo_exp = COLLISION_OFFSET_ENABLE_BASE + coll_next[3:0];
      end else if (coll_next > {1'b0, BO_LIMIT}) begin
         bo_exp = BO_LIMIT;
      end else begin
         bo_exp = coll_next[3:0];
      end
      bo_mask = 10'((11'h001 << bo_exp) - 11'h001);
   end

   // transmit sequencer with timer and backoff slots
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q   <= ST_IDLE;
         cyc_q  <= '0;
         slot_q <= '0;
         transmit_enable_out_q <= 1'b0;
      end else begin
         unique case (st_q)
            // wait for host start
            ST_IDLE: begin
               cyc_q <= '0;
               if (go_ok) begin
                  st_q   <= ST_SEND;
                  transmit_enable_out_q <= 1'b1;
               end
            end
            // frame on the wire, timer saturates
            ST_SEND: begin
               if (cyc_q != '1) begin
                  cyc_q <= cyc_q + 1'b1;
               end
               if (urun) begin
                  st_q   <= ST_IDLE;
                  transmit_enable_out_q <= 1'b0;
               end else if (coll_take) begin
                  cyc_q  <= '0;
                  transmit_enable_out_q <= 1'b0;
                  if (last_try) begin
                     st_q <= ST_IDLE;
                  end else begin
                     st_q   <= ST_BACKOFF;
                     slot_q <= lfsr_q[9:0] & bo_mask;
                  end
               end else if (done) begin
                  st_q   <= ST_IFG;
                  cyc_q  <= '0;
                  transmit_enable_out_q <= 1'b0;
               end
            end
            // count down whole slot times, then retry
            ST_BACKOFF: begin
               if (slot_q == 10'h000) begin
                  st_q   <= ST_SEND;
                  cyc_q  <= '0;
                  transmit_enable_out_q <= 1'b1;
               end else if (cyc_q == SLOT_LAST) begin
                  cyc_q  <= '0;
                  slot_q <= slot_q - 10'h001;
               end else begin
                  cyc_q <= cyc_q + 1'b1;
               end
            end
            // heartbeat window after the frame
            ST_IFG: begin
               if (hb_end) begin
                  st_q <= ST_IDLE;
               end else begin
                  cyc_q <= cyc_q + 1'b1;
               end
            end
         endcase
      end
   end

   assign transmit_enable_out = transmit_enable_out_q;
   assign tx_busy             = (st_q != ST_IDLE);

   // collision count, cleared per transmission
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         coll_cnt_q <= '0;
      end else if (go_ok) begin
         coll_cnt_q <= '0;
      end else if (coll_take) begin
         coll_cnt_q <= coll_next;
      end
   end

   // carrier watch armed after preamble, ends with enable
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         crs_mon_q <= 1'b0;
      end else if (!in_send || coll_take || urun || done) begin
         crs_mon_q <= 1'b0;
      end else if (ser_evt.preamble_done) begin
         crs_mon_q <= 1'b1;
      end
   end

   // heartbeat seen during window
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hb_seen_q <= 1'b0;
      end else if (st_q != ST_IFG) begin
         hb_seen_q <= 1'b0;
      end else if (col_q) begin
         hb_seen_q <= 1'b1;
      end
   end

   // remote transmitter disable
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_off_q <= 1'b0;
      end else if (!cfg_q.auto_transmit_disable) begin
         tx_off_q <= 1'b0;
      end else if (hash_evt.hit && hash_evt.idx == HASH_DISABLE) begin
         tx_off_q <= 1'b1;
      end else if (hash_evt.hit && hash_evt.idx == HASH_ENABLE) begin
         tx_off_q <= 1'b0;
      end
   end

   // status: cleared on start, events then set bits
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stat_q <= STATUS_RESET;
      end else begin
         if (go_ok) begin
            stat_q <= STATUS_RESET;
         end
         if (coll_take) begin
            stat_q.collided <= 1'b1;
            if (late) begin
               stat_q.late_collision_flag <= 1'b1;
            end
            if (last_try) begin
               stat_q.excess_collision_abort <= 1'b1;
            end
         end
         if (urun) begin
            stat_q.fifo_underrun_flag <= 1'b1;
         end
         if (crs_mon_q && in_send && !crs_q) begin
            stat_q.carrier_lost <= 1'b1;
         end
         if (done) begin
            stat_q.packet_sent_ok <= 1'b1;
         end
         if (hb_end && !hb_seen_q && !col_q) begin
            stat_q.heartbeat_missing <= 1'b1;
         end
      end
   end

   // read port; data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            XMIT_STATUS_ADDR: reg_rdata <= stat_q;
            COLL_COUNT_ADDR:  reg_rdata <= {3'h0, coll_cnt_q};
            XMIT_STATE_ADDR:  reg_rdata <= {4'h0, tx_off_q, transmit_enable_out_q, st_q};
            default:          reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_lb_after_reset: assert property (
      !$past(rst_n) |-> cfg_q.loopback_sel == LB_NORMAL && !loopback_pin)
      else $error("loopback not cleared by reset");

   chk_fcs_follows_write: assert property (
      reg_wr && reg_addr == XMIT_CONFIG_ADDR |=> append_fcs == !$past(reg_wdata[0]))
      else $error("fcs append does not follow inhibit bit");

   chk_lb_pin_mode: assert property (
      reg_wr && reg_addr == XMIT_CONFIG_ADDR
      |=> loopback_pin == ($past(reg_wdata[2:1]) == 2'b10))
      else $error("loopback pin wrong for mode");

   chk_status_clear: assert property (
      go_ok |=> stat_q == STATUS_RESET && transmit_enable_out_q)
      else $error("status not cleared at start");

   chk_abort_sixteen: assert property (
      coll_take && coll_cnt_q == 5'h0f
      |=> stat_q.excess_collision_abort && !transmit_enable_out_q && st_q == ST_IDLE)
      else $error("no abort at sixteenth attempt");

   chk_underrun_abort: assert property (
      urun |=> stat_q.fifo_underrun_flag && !transmit_enable_out_q ##1 !transmit_enable_out_q)
      else $error("underrun did not abort");

   chk_remote_off: assert property (
      cfg_q.auto_transmit_disable && hash_evt.hit && hash_evt.idx == HASH_DISABLE
      |=> tx_off_q ##1 !(tx_go && !$past(tx_go)) || !transmit_enable_out_q)
      else $error("remote disable not taken");

   chk_atd_clear: assert property (
      $fell(cfg_q.auto_transmit_disable) |-> ##1 !tx_off_q)
      else $error("transmitter still disabled");

   chk_backoff_window: assert property (
      coll_take && !last_try |=> (slot_q & ~$past(bo_mask)) == 10'h000)
      else $error("backoff outside window");

   chk_late_flag: assert property (
      coll_take && late && !last_try |=> stat_q.late_collision_flag && st_q == ST_BACKOFF)
      else $error("late collision not flagged");

   chk_heartbeat_miss: assert property (
      hb_end && !hb_seen_q && !col_q |=> stat_q.heartbeat_missing && st_q == ST_IDLE)
      else $error("missing heartbeat not flagged");

   chk_sent_ok: assert property (
      done |=> stat_q.packet_sent_ok && !stat_q.fifo_underrun_flag)
      else $error("sent ok not set");

   cov_retry_then_ok: cover property (coll_take ##[1:1000] done);
   cov_abort: cover property (coll_take && last_try);
   cov_carrier_lost: cover property (in_send ##1 stat_q.carrier_lost);
   cov_remote_off: cover property ($rose(tx_off_q));
endmodule

// ==== rtl/mtcs_pkg.sv ====
// package: register map, field layouts, timing and event types of the transmit block
package mtcs_pkg;
   // clock and medium timing, in their own units
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SLOT_TIME_NS  = 51200;  // 51.2 us
   localparam int unsigned HB_WINDOW_NS  = 6400;   // 6.4 us
   // slot threshold rounds up, heartbeat window rounds down
   localparam int unsigned SLOT_CYC_DEF  = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HB_CYC        = HB_WINDOW_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_W         = 16;

   // register offsets
   localparam logic [7:0] XMIT_STATUS_ADDR = 8'h04;
   localparam logic [7:0] COLL_COUNT_ADDR  = 8'h05;
   localparam logic [7:0] XMIT_STATE_ADDR  = 8'h06;
   localparam logic [7:0] XMIT_CONFIG_ADDR = 8'h0d;

   // retry and backoff figures
   localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
   localparam logic [4:0] COLLISION_OFFSET_ENABLE_COLLS   = 5'h03;
   localparam logic [3:0] BO_LIMIT     = 4'ha;
   localparam logic [3:0] COLLISION_OFFSET_ENABLE_BASE    = 4'h3;

   // remote disable hash slots
   localparam logic [5:0] HASH_DISABLE = 6'h3e;
   localparam logic [5:0] HASH_ENABLE  = 6'h3f;

   // backoff random source
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam logic [15:0] LFSR_TAPS = 16'hb400;

   // loopback encodings
   typedef enum logic [1:0] {
      LB_NORMAL    = 2'b00,
      LB_INTERNAL  = 2'b01,
      LB_EXT_PIN   = 2'b10,
      LB_EXT_QUIET = 2'b11
   } mtcs_lb_t;

   // transmit_configuration layout
   typedef struct packed {
      logic [2:0] rsvd;
      logic       collision_offset_enable;
      logic       auto_transmit_disable;
      mtcs_lb_t   loopback_sel;  // high bit loopback_sel_high
      logic       crc_inhibit;
   } mtcs_cfg_t;

   // transmit_status layout
   typedef struct packed {
      logic late_collision_flag;
      logic heartbeat_missing;
      logic fifo_underrun_flag;
      logic carrier_lost;
      logic excess_collision_abort;
      logic collided;
      logic rsvd;
      logic packet_sent_ok;
   } mtcs_status_t;

   localparam mtcs_cfg_t    CFG_RESET    = '0;
   localparam mtcs_status_t STATUS_RESET = '0;

   // serializer events, one-cycle pulses
   typedef struct packed {
      logic preamble_done;
      logic frame_done;
      logic underrun;
   } mtcs_ser_evt_t;

   // receive multicast hash hit
   typedef struct packed {
      logic       hit;
      logic [5:0] idx;
   } mtcs_hash_evt_t;

   // transmit sequencer states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SEND    = 2'b01,
      ST_BACKOFF = 2'b10,
      ST_IFG     = 2'b11
   } mtcs_state_t;
endpackage

// ==== verification/mtcs_medium_model.sv ====
// medium model: serializer events, carrier and collision lines seen by the block
`timescale 1ns/1ns
module mtcs_medium_model #(
   parameter int FRAME_CYC = 40,  // enable cycles until the last bit
   parameter int LATE_AT   = 20   // enable cycle of a late collision
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               tx_go,
   input  wire logic               transmit_enable_out,
   input  wire logic [7:0]         coll_n,
   input  wire logic               late_req,
   input  wire logic               hb_en,
   input  wire logic               crs_drop,
   input  wire logic               ufl_req,
   output mtcs_pkg::mtcs_ser_evt_t ser_evt,
   output logic                    carrier_sense_pin,
   output logic                    collision_pin
);
   import mtcs_pkg::*;
   int         cnt_q;      // cycles of the current attempt
   int         hb_q;       // cycles since the frame ended
   logic [7:0] att_q;      // attempts collided so far
   logic       hb_pend_q;  // heartbeat owed in this gap
   // the medium reacts to the enable line, one attempt at a time
   always_ff @(posedge clk_sys) begin
      ser_evt <= '0;
      if (!rst_n) begin
         cnt_q <= 0;
         hb_q <= 0;
         att_q <= '0;
         hb_pend_q <= 1'b0;
         carrier_sense_pin <= 1'b0;
         collision_pin <= 1'b0;
      end else begin
         // a new packet gets a fresh collision budget
         if (tx_go) begin
            att_q <= '0;
         end
         if (transmit_enable_out) begin
            cnt_q <= cnt_q + 1;
            // a new attempt cancels any heartbeat still owed from an aborted one
            if (cnt_q == 0) begin
               hb_pend_q <= 1'b0;
               collision_pin <= 1'b0;
            end
            // own signal returns as carrier unless the medium loses it
            carrier_sense_pin <= !(crs_drop && cnt_q > 10);
            if (cnt_q == 4) begin
               ser_evt.preamble_done <= 1'b1;
            end
            if (ufl_req && cnt_q == 6) begin
               ser_evt.underrun <= 1'b1;
               hb_pend_q <= hb_en;
               hb_q <= 0;
            end
            // collision held until the block drops its enable
            if (att_q < coll_n && cnt_q == (late_req ? LATE_AT : 1)) begin
               collision_pin <= 1'b1;
               att_q <= att_q + 8'h01;
            end
            if (cnt_q == FRAME_CYC) begin
               ser_evt.frame_done <= 1'b1;
               hb_pend_q <= hb_en;
               hb_q <= 0;
            end
         end else begin
            cnt_q <= 0;
            carrier_sense_pin <= 1'b0;
            hb_q <= hb_q + 1;
            // heartbeat burst early in the gap, only when enabled
            collision_pin <= hb_pend_q && hb_q >= 10 && hb_q < 20;
            if (hb_q == 20) begin
               hb_pend_q <= 1'b0;
            end
         end
      end
   end
endmodule

// ==== verification/mtcs_top_tb.sv ====
// self-checking bench of the transmit configuration and status block
`timescale 1ns/1ns
module mtcs_top_tb;
   import mtcs_pkg::*;
   localparam int unsigned SLOT = 8;  // shortened slot time in cycles
   logic           clk_sys;
   logic           rst_n;
   logic [7:0]     reg_addr;
   logic [7:0]     reg_wdata;
   logic           reg_wr;
   logic           reg_rd;
   logic [7:0]     reg_rdata;
   logic           tx_go;
   mtcs_ser_evt_t  ser_evt;
   mtcs_hash_evt_t hash_evt;
   logic           carrier_sense_pin;
   logic           collision_pin;
   logic           transmit_enable_out;
   logic           append_fcs;
   logic           loopback_pin;
   logic           internal_loopback;
   logic           external_loopback;
   logic           tx_busy;
   logic [7:0]     coll_n;     // attempts the medium collides
   logic           late_req;   // collide late instead of early
   logic           hb_en;      // medium gives a heartbeat
   logic           crs_drop;   // medium loses carrier
   logic           ufl_req;    // serializer runs dry
   logic [7:0]     rd_v;       // last read value
   int             gap;        // first backoff gap in cycles
   int             fails;
   int             samples_checked;

   mtcs_top #(.SLOT_CYC(SLOT)) i_mtcs_top (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_go(tx_go),
      .ser_evt(ser_evt), .hash_evt(hash_evt), .carrier_sense_pin(carrier_sense_pin),
      .collision_pin(collision_pin), .transmit_enable_out(transmit_enable_out),
      .append_fcs(append_fcs), .loopback_pin(loopback_pin),
      .internal_loopback(internal_loopback), .external_loopback(external_loopback),
      .tx_busy(tx_busy));

   mtcs_medium_model i_mtcs_medium_model (
      .clk_sys(clk_sys), .rst_n(rst_n), .tx_go(tx_go),
      .transmit_enable_out(transmit_enable_out), .coll_n(coll_n), .late_req(late_req),
      .hb_en(hb_en), .crs_drop(crs_drop), .ufl_req(ufl_req), .ser_evt(ser_evt),
      .carrier_sense_pin(carrier_sense_pin), .collision_pin(collision_pin));

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // report counts and verdict, then stop
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // compare one byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // bound the first backoff gap
   task automatic chk_gap(input int hi);
      samples_checked++;
      if (gap < 1 || gap > hi) begin
         fails++;
         $display("MISMATCH at %0t: backoff gap %0d above %0d", $time, gap, hi);
      end
   endtask

   // one-cycle write strobe
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // one-cycle read strobe, data taken in the following cycle
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // host start pulse
   task automatic pulse_go();
      @(posedge clk_sys);
      tx_go <= 1'b1;
      @(posedge clk_sys);
      tx_go <= 1'b0;
   endtask

   // multicast hash hit pulse
   task automatic hash_hit(input logic [5:0] idx);
      @(posedge clk_sys);
      hash_evt <= '{hit: 1'b1, idx: idx};
      @(posedge clk_sys);
      hash_evt <= '0;
   endtask

   // wait for idle, measuring the first low gap between attempts
   task automatic wait_idle(input int bound);
      int n;
      int lo;
      bit seen;
      gap = -1;
      lo = 0;
      seen = 1'b0;
      for (n = 0; n < bound; n++) begin
         @(posedge clk_sys);
         #1;
         if (transmit_enable_out === 1'b1) begin
            if (lo > 0 && gap < 0) gap = lo;
            seen = 1'b1;
         end else if (seen) begin
            lo++;
         end
         if (tx_busy === 1'b0) break;
      end
      if (n >= bound) begin
         fails++;
         $display("MISMATCH at %0t: transmission never finished", $time);
         give_verdict();
      end
   endtask

   // full transmission, then status and collision count
   task automatic send(input int bound, input logic [7:0] st, input logic [7:0] cnt);
      pulse_go();
      wait_idle(bound);
      reg_read(XMIT_STATUS_ADDR, rd_v);
      chk(rd_v, st, "status");
      reg_read(COLL_COUNT_ADDR, rd_v);
      chk(rd_v, cnt, "collision count");
   endtask

   // reset outputs, all eight loopback and fcs codes, write-only and unmapped reads
   task automatic sc_config();
      logic [7:0] got;
      got = {4'h0, loopback_pin, internal_loopback, external_loopback, append_fcs};
      chk(got, 8'h01, "reset outputs");
      for (int i = 0; i < 8; i++) begin
         // host also clears its data path loopback select
         reg_write(XMIT_CONFIG_ADDR, 8'(i));
         reg_write(XMIT_STATUS_ADDR, 8'h06);
         @(posedge clk_sys);
         #1;
         got = {4'h0, loopback_pin, internal_loopback, external_loopback, append_fcs};
         chk(got, {4'h0, i[2:1] == 2'b10, i[2:1] == 2'b01, i[2], !i[0]}, "cfg");
      end
      reg_read(XMIT_CONFIG_ADDR, rd_v);
      chk(rd_v, 8'h00, "write-only read");
      reg_read(8'h3f, rd_v);
      chk(rd_v, 8'h00, "unmapped read");
      reg_write(XMIT_CONFIG_ADDR, 8'h00);
   endtask

   // remote disable and the two ways back
   task automatic sc_remote();
      reg_write(XMIT_CONFIG_ADDR, 8'h08);
      hash_hit(6'd62);
      pulse_go();
      @(posedge clk_sys);
      #1;
      chk({7'h0, tx_busy | transmit_enable_out}, 8'h00, "start while disabled");
      reg_read(XMIT_STATE_ADDR, rd_v);
      chk(rd_v & 8'h08, 8'h08, "disable flag");
      hash_hit(6'd63);
      send(2000, 8'h01, 8'h00);
      hash_hit(6'd62);
      reg_write(XMIT_CONFIG_ADDR, 8'h00);
      @(posedge clk_sys);
      send(2000, 8'h01, 8'h00);
   endtask

   // main sequence
   initial begin
      fails = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_go = 1'b0;
      hash_evt = '0;
      coll_n = 8'h00;
      late_req = 1'b0;
      hb_en = 1'b1;
      crs_drop = 1'b0;
      ufl_req = 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      sc_config();
      send(2000, 8'h01, 8'h00);
      hb_en = 1'b0;
      send(2000, 8'h41, 8'h00);
      hb_en = 1'b1;
      pulse_go();
      reg_read(XMIT_STATUS_ADDR, rd_v);
      chk(rd_v, 8'h00, "status at start");
      wait_idle(2000);
      crs_drop = 1'b1;
      send(2000, 8'h11, 8'h00);
      crs_drop = 1'b0;
      ufl_req = 1'b1;
      send(2000, 8'h20, 8'h00);
      ufl_req = 1'b0;
      coll_n = 8'h03;
      send(5000, 8'h05, 8'h03);
      chk_gap(SLOT + 6);
      reg_write(XMIT_CONFIG_ADDR, 8'h10);
      coll_n = 8'h02;
      send(5000, 8'h05, 8'h02);
      chk_gap(15 * SLOT + 6);
      reg_write(XMIT_CONFIG_ADDR, 8'h00);
      coll_n = 8'h01;
      late_req = 1'b1;
      send(5000, 8'h85, 8'h01);
      late_req = 1'b0;
      coll_n = 8'hff;
      send(70000, 8'h0c, 8'h10);
      coll_n = 8'h00;
      sc_remote();
      give_verdict();
   end
endmodule
